/* rtl/ep_irq_pkg.sv */
// Constants and carrier types for the endpoint interrupt status and clear block
package ep_irq_pkg;
  localparam int          DATA_W         = 32;
  localparam int          EP_BITS        = 32;
  localparam int          LOG_EP_W       = 16;
  localparam int          IDX_W          = 5;
  // Register byte addresses
  localparam logic [31:0] ADDR_STATUS    = 32'hE0090030;
  localparam logic [31:0] ADDR_ENABLE    = 32'hE0090034;
  localparam logic [31:0] ADDR_CLEAR     = 32'hE0090038;
  localparam logic [31:0] ADDR_PRIORITY  = 32'hE0090040;
  localparam logic [31:0] ADDR_CONTROL   = 32'hE0090060;
  localparam logic [31:0] ADDR_CMD_DATA  = 32'hE0090064;
  localparam logic [31:0] ADDR_DIRECT    = 32'hE0090068;
  // Field positions
  localparam int          CTRL_NAK_POS   = 0;
  localparam int          CDATA_FULL_POS = 8;
  // Reset values
  localparam logic [31:0] RESET_WORD     = 32'h00000000;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  // Physical bits of the isochronous endpoints 3, 6, 9 and 12
  localparam logic [31:0] ISO_MASK       = 32'h030C30C0;
  // Select endpoint / clear interrupt command base, 0x40 to 0x5F
  localparam logic [7:0]  CMD_SEL_CLR    = 8'h40;
  localparam logic [7:0]  CMD_SEL_CLR_HI = 8'h5F;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_FLUSH = 2'b01,
    SEQ_ISSUE = 2'b10,
    SEQ_WAIT  = 2'b11
  } seq_state_t;

  // Command towards the protocol engine
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } pe_cmd_t;

  // Answer from the protocol engine
  typedef struct packed {
    logic       done;
    logic [7:0] data;
  } pe_rsp_t;
endpackage : ep_irq_pkg

/* rtl/usb_endpoint_irq_status_clear.sv */
// Endpoint interrupt status, enable, priority and clear sequencer with APB access
// Operation
// - Every non-isochronous endpoint has a receive and a transmit status bit.
// - Isochronous endpoint bit pairs have no interrupt function.
// - Enabled status bits forward into the device interrupt flags; disabled ones do not.
// - A forwarded interrupt sets the fast or the slow endpoint flag.
// - Any enable bit set means the endpoint runs in slave mode.
// - Writing one to a clear bit clears that status bit; zero does nothing.
// - A clear first drops command-data-full, then issues the select/clear command.
// - On completion the status goes to command data and the flag sets.
// - A direct select/clear command also clears the endpoint interrupt.
// - Status and command-data-full are coupled through the clear in one clock domain.
// - Multiple clears run highest endpoint first; lowest endpoint's status remains.
// - Each clear step completes before the next, without waiting for software.
// - The clear register has one bit per physical endpoint, as status.
// - Receive status rises only for an error-free packet.
// - Transmit status from a NAK rises only while NAK interrupts are on.
// - Priority one steers to the fast flag, zero to the slow flag.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module usb_endpoint_irq_status_clear #(
  parameter logic [31:0] ISO_BITS = ep_irq_pkg::ISO_MASK
) (
  input  wire logic                clock_i,
  input  wire logic                rst_b_i,
  input  wire logic                ce_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [31:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic [15:0]         endpoint_receive_event_i,
  input  wire logic [15:0]         endpoint_receive_error_i,
  input  wire logic [15:0]         endpoint_transmit_event_i,
  input  wire logic [15:0]         endpoint_nak_event_i,
  output ep_irq_pkg::pe_cmd_t      pe_cmd_o,
  input  wire ep_irq_pkg::pe_rsp_t pe_rsp_i,
  output logic                     fast_endpoint_flag_o,
  output logic                     slow_endpoint_flag_o,
  output logic                     command_data_full_flag_o,
  output logic                     slave_mode_o
);

  // Endpoint 0 carries setup traffic, so its status pair must stay live
  if (ISO_BITS[1:0] != 2'b00)
  begin : g_iso_check
    $error("Control endpoint 0 cannot be isochronous");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Highest set bit; the sequencer walks endpoints from the top down
  function automatic logic [4:0] top_index(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (v[i])
      begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : top_index

  // Logical endpoint vectors into the RX/TX interleaved physical layout
  function automatic logic [31:0] interleave(input logic [15:0] rx, input logic [15:0] tx);
    logic [31:0] v;
    v = 32'h00000000;
    for (int i = 0; i < 16; i++)
    begin
      v[2*i]   = rx[i];
      v[2*i+1] = tx[i];
    end
    return v;
  endfunction : interleave

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic [31:0]            endpoint_irq_status;
  logic [31:0]            endpoint_irq_enable;
  logic [31:0]            endpoint_irq_priority;
  logic                   nak_irq_enable;
  logic [31:0]            clear_pending;
  logic [4:0]             seq_index;
  logic [7:0]             command_data;
  ep_irq_pkg::seq_state_t seq_state;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode: no wait states, read data and answers come from flip-flops loaded in the setup cycle

  wire         apb_setup  = psel_i & ~penable_i;
  wire         apb_done   = psel_i & penable_i & pready_o;
  wire         apb_wr     = apb_done & pwrite_i & ~pslverr_o;
  wire         hit_status = (paddr_i == ep_irq_pkg::ADDR_STATUS);
  wire         hit_enable = (paddr_i == ep_irq_pkg::ADDR_ENABLE);
  wire         hit_clear  = (paddr_i == ep_irq_pkg::ADDR_CLEAR);
  wire         hit_prio   = (paddr_i == ep_irq_pkg::ADDR_PRIORITY);
  wire         hit_ctrl   = (paddr_i == ep_irq_pkg::ADDR_CONTROL);
  wire         hit_cdata  = (paddr_i == ep_irq_pkg::ADDR_CMD_DATA);
  wire         hit_direct = (paddr_i == ep_irq_pkg::ADDR_DIRECT);
  // Status and command data are read-only, clear and direct are write-only
  wire         rd_ok      = hit_status | hit_enable | hit_prio | hit_ctrl | hit_cdata;
  wire         wr_ok      = hit_enable | hit_clear | hit_prio | hit_ctrl | hit_direct;
  wire         bad_access = pwrite_i ? ~wr_ok : ~rd_ok;
  wire [31:0]  read_mux   =
      hit_status ? endpoint_irq_status :
      hit_enable ? endpoint_irq_enable :
      hit_prio   ? endpoint_irq_priority :
      hit_ctrl   ? {31'h00000000, nak_irq_enable} :
      hit_cdata  ? {23'h000000, command_data_full_flag_o, command_data} :
                   ep_irq_pkg::RESET_WORD;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= ep_irq_pkg::RESET_WORD;
    end
    else if (ce_i)
    begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup & bad_access;
      prdata_o  <= (apb_setup & ~pwrite_i & ~bad_access) ? read_mux : ep_irq_pkg::RESET_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers

  wire [31:0] clear_write  = (apb_wr & hit_clear) ? pwdata_i : 32'h00000000;
  wire [31:0] direct_write = (apb_wr & hit_direct) ? (32'h00000001 << pwdata_i[4:0])
                                                   : 32'h00000000;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      endpoint_irq_enable   <= ep_irq_pkg::RESET_WORD;
      endpoint_irq_priority <= ep_irq_pkg::RESET_WORD;
      nak_irq_enable        <= 1'b0;
    end
    else if (ce_i)
    begin
      if (apb_wr & hit_enable)
      begin
        endpoint_irq_enable <= pwdata_i;
      end
      if (apb_wr & hit_prio)
      begin
        endpoint_irq_priority <= pwdata_i;
      end
      if (apb_wr & hit_ctrl)
      begin
        nak_irq_enable <= pwdata_i[ep_irq_pkg::CTRL_NAK_POS];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Endpoint status: sticky, set wins over clear

  wire [31:0] rx_ok     = interleave(endpoint_receive_event_i & ~endpoint_receive_error_i,
                                     16'h0000);
  wire [31:0] tx_ok     = interleave(16'h0000, endpoint_transmit_event_i |
                                     (endpoint_nak_event_i & {16{nak_irq_enable}}));
  // Isochronous pairs are held at zero, they follow the frame interrupt instead
  wire [31:0] set_bits  = (rx_ok | tx_ok) & ~ISO_BITS;
  wire [31:0] clr_bits  = clear_write | direct_write;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      endpoint_irq_status <= ep_irq_pkg::RESET_WORD;
    end
    else if (ce_i)
    begin
      endpoint_irq_status <= (endpoint_irq_status & ~clr_bits) | set_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Forwarding into the device-level flags

  wire [31:0] forwarded = endpoint_irq_status & endpoint_irq_enable;
  wire        fast_hit  = |(forwarded & endpoint_irq_priority);
  wire        slow_hit  = |(forwarded & ~endpoint_irq_priority);

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      fast_endpoint_flag_o <= 1'b0;
      slow_endpoint_flag_o <= 1'b0;
      slave_mode_o         <= 1'b0;
    end
    else if (ce_i)
    begin
      fast_endpoint_flag_o <= fast_hit;
      slow_endpoint_flag_o <= slow_hit;
      slave_mode_o         <= |endpoint_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clear sequencer towards the protocol engine

  wire       seq_start = (seq_state == ep_irq_pkg::SEQ_IDLE) & (|clear_pending);
  wire       seq_end   = (seq_state == ep_irq_pkg::SEQ_WAIT) & pe_rsp_i.done;
  wire [4:0] next_index = top_index(clear_pending);
  ep_irq_pkg::seq_state_t next_state;

  always_comb
  begin
    next_state = seq_state;
    unique case (seq_state)
      ep_irq_pkg::SEQ_IDLE:  next_state = seq_start ? ep_irq_pkg::SEQ_FLUSH : seq_state;
      ep_irq_pkg::SEQ_FLUSH: next_state = ep_irq_pkg::SEQ_ISSUE;
      ep_irq_pkg::SEQ_ISSUE: next_state = ep_irq_pkg::SEQ_WAIT;
      ep_irq_pkg::SEQ_WAIT:  next_state = pe_rsp_i.done ? ep_irq_pkg::SEQ_IDLE : seq_state;
    endcase
  end

  // A clear written mid-sequence joins the queue; the finished bit drops unless rewritten
  wire [31:0] done_bit = seq_end ? (32'h00000001 << seq_index) : 32'h00000000;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      seq_state                <= ep_irq_pkg::SEQ_IDLE;
      clear_pending            <= ep_irq_pkg::RESET_WORD;
      seq_index                <= 5'h00;
      command_data             <= ep_irq_pkg::RESET_BYTE;
      command_data_full_flag_o <= 1'b0;
      pe_cmd_o                 <= '0;
    end
    else if (ce_i)
    begin
      seq_state     <= next_state;
      clear_pending <= (clear_pending & ~done_bit) | clr_bits;
      pe_cmd_o.valid <= (seq_state == ep_irq_pkg::SEQ_FLUSH);
      if (seq_start)
      begin
        seq_index                <= next_index;
        command_data_full_flag_o <= 1'b0;
      end
      if (seq_state == ep_irq_pkg::SEQ_FLUSH)
      begin
        pe_cmd_o.code <= ep_irq_pkg::CMD_SEL_CLR | {3'b000, seq_index};
      end
      if (seq_end)
      begin
        command_data             <= pe_rsp_i.data;
        command_data_full_flag_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_clear_start;
    ce_i && seq_start;
  endsequence

  sequence s_issue;
    ##1 (seq_state == ep_irq_pkg::SEQ_FLUSH && !command_data_full_flag_o)
    ##1 pe_cmd_o.valid;
  endsequence

  a_iso_bits_zero: assert property ((endpoint_irq_status & ISO_BITS) == 32'h00000000)
    else $error("Isochronous status bit set");

  a_clear_drops_bit: assert property (ce_i && (|clr_bits)
      |=> (endpoint_irq_status & $past(clr_bits) & ~$past(set_bits)) == 32'h00000000)
    else $error("Clear write left status bit set");

  a_status_sticky: assert property (ce_i
      |=> (~endpoint_irq_status & $past(endpoint_irq_status) & ~$past(clr_bits))
          == 32'h00000000)
    else $error("Status bit dropped without a clear");

  a_set_beats_clear: assert property (ce_i && set_bits[2] |=> endpoint_irq_status[2])
    else $error("Status event lost");

  a_flush_before_cmd: assert property (s_clear_start |-> s_issue)
    else $error("Command issued without flushing command-data-full");

  a_cmd_code_range: assert property (pe_cmd_o.valid
      |-> (pe_cmd_o.code >= ep_irq_pkg::CMD_SEL_CLR
      && pe_cmd_o.code <= ep_irq_pkg::CMD_SEL_CLR_HI))
    else $error("Command code out of range");

  a_cmd_pulse: assert property (ce_i && pe_cmd_o.valid |=> !pe_cmd_o.valid)
    else $error("Command valid held longer than one cycle");

  a_done_sets_full: assert property (ce_i && seq_end
      |=> command_data_full_flag_o && command_data == $past(pe_rsp_i.data))
    else $error("Completion did not load command data");

  a_full_waits: assert property (ce_i && !pe_rsp_i.done
      && seq_state == ep_irq_pkg::SEQ_WAIT |=> !command_data_full_flag_o)
    else $error("Command-data-full set before completion");

  a_high_first: assert property (s_clear_start
      |=> seq_index == $past(next_index)
      && (($past(clear_pending) >> seq_index) >> 1) == 32'h00000000)
    else $error("Clear did not start at highest endpoint");

  a_fast_route: assert property (ce_i && |(forwarded & endpoint_irq_priority)
      |=> fast_endpoint_flag_o)
    else $error("Fast-priority endpoint missed fast flag");

  a_slow_route: assert property (ce_i && |(forwarded & ~endpoint_irq_priority)
      |=> slow_endpoint_flag_o)
    else $error("Slow-priority endpoint missed slow flag");

  a_slave_follows: assert property (ce_i && endpoint_irq_enable != 32'h00000000
      |=> slave_mode_o)
    else $error("Slave mode missing with an enable bit set");

  a_disabled_quiet: assert property (ce_i && endpoint_irq_enable == 32'h00000000
      |=> !fast_endpoint_flag_o && !slow_endpoint_flag_o && !slave_mode_o)
    else $error("Flag raised with all enables off");

  // A frozen block must not lose or invent state, nor answer the bus
  a_ce_freeze: assert property (!ce_i
      |=> $stable(endpoint_irq_status) && $stable(seq_state) && $stable(pready_o))
    else $error("State moved while the clock enable was low");

endmodule : usb_endpoint_irq_status_clear
`default_nettype wire

/* tb/pe_model.sv */
// Protocol engine stand-in answering select/clear commands
`timescale 1ns/1ns
`default_nettype none
module pe_model (
  input  wire logic                clock_i,
  input  wire logic                slow_i,
  input  wire ep_irq_pkg::pe_cmd_t cmd_i,
  output var  ep_irq_pkg::pe_rsp_t rsp_o
);
  initial rsp_o = '0;
  // Status byte is derived from the code so each endpoint answers differently
  always @(posedge clock_i)
  begin
    if (cmd_i.valid === 1'h1)
    begin
      repeat (slow_i ? 6 : 1) @(posedge clock_i);
      rsp_o <= '{done: 1'h1, data: cmd_i.code ^ 8'h3C};
      @(posedge clock_i);
      // Released byte is inverted so a stale value never passes for fresh data
      rsp_o <= '{done: 1'h0, data: ~rsp_o.data};
    end
  end
endmodule : pe_model
`default_nettype wire

/* tb/tb_usb_endpoint_irq_status_clear.sv */
// Self-checking bench for the endpoint interrupt status and clear block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_usb_endpoint_irq_status_clear;
  logic                clock_i = 1'h0;
  logic                rst_b_i = 1'h0;
  logic                psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0, ce = 1'h1;
  logic [31:0]         paddr = 32'h0, pwdata = 32'h0, prdata, rdata;
  logic                pready, pslverr, rerr, fast_flag, slow_flag, full_flag, slave;
  logic [15:0]         rx_ev = 16'h0, rx_er = 16'h0, tx_ev = 16'h0, nak_ev = 16'h0;
  ep_irq_pkg::pe_cmd_t cmd;
  ep_irq_pkg::pe_rsp_t rsp;
  logic [7:0]          codes[$];
  logic                flags[$];
  int                  err_count = 0;
  int                  checked = 0;

  always #4 clock_i = ~clock_i;

  usb_endpoint_irq_status_clear u_usb_endpoint_irq_status_clear (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .endpoint_receive_event_i(rx_ev), .endpoint_receive_error_i(rx_er),
    .endpoint_transmit_event_i(tx_ev), .endpoint_nak_event_i(nak_ev),
    .pe_cmd_o(cmd), .pe_rsp_i(rsp), .fast_endpoint_flag_o(fast_flag),
    .slow_endpoint_flag_o(slow_flag), .command_data_full_flag_o(full_flag),
    .slave_mode_o(slave));

  pe_model u_pe_model (.clock_i(clock_i), .slow_i(slow), .cmd_i(cmd), .rsp_o(rsp));

  // Command pulses last one cycle, so they are logged here rather than polled
  always @(posedge clock_i)
  begin
    if (cmd.valid === 1'h1)
    begin
      codes.push_back(cmd.code);
      flags.push_back(full_flag);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'h1;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (n >= 50)
    begin
      err_count++;
      wrap_up();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wait_seq(input int n);
    int k;
    k = 0;
    while ((codes.size() < n || full_flag !== 1'h1) && k < 200)
    begin
      @(posedge clock_i);
      k++;
    end
    if (k >= 200)
    begin
      err_count++;
      wrap_up();
    end
  endtask : wait_seq

  task automatic events(input logic [15:0] r, e, t, k);
    @(posedge clock_i);
    rx_ev <= r;
    rx_er <= e;
    tx_ev <= t;
    nak_ev <= k;
    @(posedge clock_i);
    {rx_ev, rx_er, tx_ev, nak_ev} <= 64'h0;
    @(posedge clock_i);
  endtask : events
  //////////////////////////////////////////////////////////////////////////////
  task automatic check_reset;
    apb(1'h0, ep_irq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rdata, 32'h0)
    apb(1'h0, ep_irq_pkg::ADDR_ENABLE, 32'h0);
    `CHK(rdata, 32'h0)
    apb(1'h0, ep_irq_pkg::ADDR_CLEAR, 32'h0);
    `CHK(rerr, 1'h1)
    apb(1'h1, ep_irq_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    `CHK(rerr, 1'h1)
    apb(1'h0, 32'hE0090050, 32'h0);
    `CHK(rerr, 1'h1)
    `CHK({fast_flag, slow_flag, full_flag, slave}, 4'h0)
  endtask : check_reset

  task automatic set_events;
    // Error packet, NAK with the feature off and iso endpoint 3 must not show
    events(16'h001A, 16'h0010, 16'h000C, 16'h0020);
    apb(1'h0, ep_irq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rdata, 32'h00000024)
    apb(1'h1, ep_irq_pkg::ADDR_CONTROL, 32'h1);
    events(16'h0400, 16'h0000, 16'h0000, 16'h0020);
    apb(1'h0, ep_irq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rdata, 32'h00100824)
  endtask : set_events

  task automatic routing;
    `CHK({fast_flag, slow_flag, slave}, 3'h0)
    apb(1'h1, ep_irq_pkg::ADDR_ENABLE, 32'h4);
    repeat (2) @(posedge clock_i);
    `CHK({fast_flag, slow_flag, slave}, 3'h3)
    apb(1'h1, ep_irq_pkg::ADDR_PRIORITY, 32'h4);
    repeat (2) @(posedge clock_i);
    `CHK({fast_flag, slow_flag}, 2'h2)
    apb(1'h0, ep_irq_pkg::ADDR_ENABLE, 32'h0);
    `CHK(rdata, 32'h4)
  endtask : routing

  task automatic multi_clear;
    slow <= 1'h1;
    apb(1'h1, ep_irq_pkg::ADDR_CLEAR, 32'h0);
    apb(1'h0, ep_irq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rdata, 32'h00100824)
    apb(1'h1, ep_irq_pkg::ADDR_CLEAR, 32'h00000804);
    apb(1'h0, ep_irq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rdata, 32'h00100020)
    wait_seq(2);
    `CHK({codes[0], codes[1]}, 16'h4B42)
    `CHK({flags[0], flags[1]}, 2'h0)
    apb(1'h0, ep_irq_pkg::ADDR_CMD_DATA, 32'h0);
    `CHK(rdata, 32'h0000017E)
    `CHK({fast_flag, slow_flag}, 2'h0)
  endtask : multi_clear

  task automatic direct_cmd;
    slow <= 1'h0;
    apb(1'h1, ep_irq_pkg::ADDR_DIRECT, 32'h14);
    wait_seq(3);
    `CHK({codes[2], flags[2]}, 9'h0A8)
    apb(1'h0, ep_irq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rdata, 32'h00000020)
    apb(1'h0, ep_irq_pkg::ADDR_CMD_DATA, 32'h0);
    `CHK(rdata, 32'h00000168)
  endtask : direct_cmd

  task automatic freeze;
    // Events that land while the enable is low are lost by design
    ce <= 1'h0;
    events(16'h2000, 16'h0000, 16'h0000, 16'h0000);
    ce <= 1'h1;
    apb(1'h0, ep_irq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rdata, 32'h00000020)
    events(16'h2000, 16'h0000, 16'h0000, 16'h0000);
    apb(1'h0, ep_irq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rdata, 32'h04000020)
  endtask : freeze

  task automatic mid_reset;
    @(posedge clock_i);
    rst_b_i <= 1'h0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'h1;
    apb(1'h0, ep_irq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rdata, 32'h0)
    apb(1'h0, ep_irq_pkg::ADDR_ENABLE, 32'h0);
    `CHK(rdata, 32'h0)
    `CHK({slave, full_flag}, 2'h0)
  endtask : mid_reset

  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'h1;
    check_reset();
    set_events();
    routing();
    multi_clear();
    direct_cmd();
    freeze();
    mid_reset();
    wrap_up();
  end
endmodule : tb_usb_endpoint_irq_status_clear
`default_nettype wire
